/* hdl/arct_timer.sv */
`timescale 1ns/1ps
module arct_timer (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic       sfr_bit_wr,
  input  wire logic [2:0] sfr_bit_idx,
  input  wire logic       sfr_bit_val,
  output logic      [7:0] sfr_rdata,
  input  wire logic       timer_irq_enable,
  input  wire logic       high_half_clock_select,
  input  wire logic       low_half_clock_select,
  input  wire logic       rtc_clk,
  input  wire logic       cmp_out,
  output logic            irq_request
);

  logic [7:0]  ctrl_r,  ctrl_nxt;
  logic [15:0] cnt_r,   cnt_nxt;
  logic [15:0] rld_r,   rld_nxt;
  logic [7:0]  rdat_r,  rdat_nxt;
  logic        irq_r,   irq_nxt;
  logic [7:0]  ctrl_sw;
  logic        tick_lo, tick_hi, inc_lo, inc_hi, ovf_lo, ovf_hi, capt;
  logic        split, run, ctrl_hit;
  logic [1:0]  xclk;

  arct_tick_if tk ();

  arct_tick_gen u_tick (
    .mclk    (mclk),
    .rst     (rst),
    .rtc_clk (rtc_clk),
    .cmp_out (cmp_out),
    .tk      (tk)
  );

  // ----------------------------------------------------------------
  // tick source selection
  // ----------------------------------------------------------------
  // source decode, reserved code ticks only when sys_sel is set
  function automatic logic pick_tick(input logic sys_sel, input logic [1:0] code,
                                     input logic s12, input logic r8, input logic cr);
    logic t;
    t = 1'b0;
    if (sys_sel)
      t = 1'b1;
    else
      case (code)
        arct_pkg::XCLK_SYS12: t = s12;
        arct_pkg::XCLK_RTC8:  t = r8;
        arct_pkg::XCLK_CMP:   t = cr;
        default:              t = 1'b0;
      endcase
    return t;
  endfunction : pick_tick

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    xclk     = ctrl_r[arct_pkg::BIT_XCLK_HI:arct_pkg::BIT_XCLK_LO];
    split    = ctrl_r[arct_pkg::BIT_SPLIT];
    run      = ctrl_r[arct_pkg::BIT_RUN];
    tick_lo  = pick_tick(low_half_clock_select, xclk, tk.sys12, tk.rtc8, tk.cmp_rise);
    tick_hi  = pick_tick(high_half_clock_select, xclk, tk.sys12, tk.rtc8, tk.cmp_rise);
    // split low half free-running, high gated by run
    inc_lo   = split ? tick_lo : (tick_lo & run);
    inc_hi   = split ? (tick_hi & run) : (inc_lo & (cnt_r[7:0] == 8'hff));
    ovf_lo   = inc_lo & (cnt_r[7:0] == 8'hff);
    ovf_hi   = inc_hi & (cnt_r[15:8] == 8'hff);
    // event source by select bit 1
    capt     = ctrl_r[arct_pkg::BIT_CAPT_EN] &
               (xclk[1] ? tk.cmp_rise : tk.rtc8);

    // byte write or single-bit write to control
    ctrl_hit = (sfr_addr == arct_pkg::OFS_CTRL);
    ctrl_sw  = ctrl_r;
    if (sfr_wr && ctrl_hit)
      ctrl_sw = sfr_wdata;
    else if (sfr_bit_wr && ctrl_hit)
      ctrl_sw[sfr_bit_idx] = sfr_bit_val;
    ctrl_nxt = ctrl_sw;
    // hardware only sets flags; set beats clear
    if (ovf_hi || capt)
      ctrl_nxt[arct_pkg::BIT_HIGH_FLAG] = 1'b1;
    if (ovf_lo)
      ctrl_nxt[arct_pkg::BIT_LOW_FLAG] = 1'b1;

    // each half reloads from its own byte
    cnt_nxt = cnt_r;
    if (inc_lo)
      cnt_nxt[7:0] = ovf_lo ? (split ? rld_r[7:0] : 8'h00) : cnt_r[7:0] + 8'h01;
    if (inc_hi)
      cnt_nxt[15:8] = ovf_hi ? rld_r[15:8] : cnt_r[15:8] + 8'h01;
    if (!split && ovf_hi)
      cnt_nxt = rld_r;
    if (sfr_wr && sfr_addr == arct_pkg::OFS_CNT_LO)
      cnt_nxt[7:0] = sfr_wdata;
    if (sfr_wr && sfr_addr == arct_pkg::OFS_CNT_HI)
      cnt_nxt[15:8] = sfr_wdata;

    rld_nxt = rld_r;
    if (sfr_wr && sfr_addr == arct_pkg::OFS_RLD_LO)
      rld_nxt[7:0] = sfr_wdata;
    if (sfr_wr && sfr_addr == arct_pkg::OFS_RLD_HI)
      rld_nxt[15:8] = sfr_wdata;
    // capture copies count, overrides software write
    if (capt)
      rld_nxt = cnt_r;

    rdat_nxt = rdat_r;
    if (sfr_rd)
      case (sfr_addr)
        arct_pkg::OFS_CTRL:   rdat_nxt = ctrl_r;
        arct_pkg::OFS_RLD_LO: rdat_nxt = rld_r[7:0];
        arct_pkg::OFS_RLD_HI: rdat_nxt = rld_r[15:8];
        arct_pkg::OFS_CNT_LO: rdat_nxt = cnt_r[7:0];
        arct_pkg::OFS_CNT_HI: rdat_nxt = cnt_r[15:8];
        default:              rdat_nxt = 8'h00;
      endcase

    // low flag joins when low enable set
    irq_nxt = timer_irq_enable &
              (ctrl_r[arct_pkg::BIT_HIGH_FLAG] |
               (ctrl_r[arct_pkg::BIT_LOW_IRQEN] & ctrl_r[arct_pkg::BIT_LOW_FLAG]));
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_r <= arct_pkg::RST_CTRL;
      cnt_r  <= arct_pkg::RST_COUNT;
      rld_r  <= arct_pkg::RST_RLD;
      rdat_r <= 8'h00;
      irq_r  <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      cnt_r  <= cnt_nxt;
      rld_r  <= rld_nxt;
      rdat_r <= rdat_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign sfr_rdata   = rdat_r;
  assign irq_request = irq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_full_reload: assert property (@(posedge mclk) disable iff (rst)
    (!split && inc_lo && cnt_r == 16'hffff && !sfr_wr && !capt) |=>
      cnt_r == $past(rld_r) && ctrl_r[arct_pkg::BIT_HIGH_FLAG])
    else $error("16-bit rollover did not reload or flag");
  a_run_gates: assert property (@(posedge mclk) disable iff (rst)
    (!split && !run && !sfr_wr) |=> cnt_r == $past(cnt_r))
    else $error("16-bit count moved while stopped");
  a_split_low_free: assert property (@(posedge mclk) disable iff (rst)
    (split && !run && tick_lo && cnt_r[7:0] != 8'hff && !sfr_wr) |=>
      cnt_r[7:0] == $past(cnt_r[7:0]) + 8'h01 && cnt_r[15:8] == $past(cnt_r[15:8]))
    else $error("split low half not free running");
  a_split_low_rld: assert property (@(posedge mclk) disable iff (rst)
    (split && tick_lo && cnt_r[7:0] == 8'hff && !sfr_wr) |=>
      cnt_r[7:0] == $past(rld_r[7:0]) && ctrl_r[arct_pkg::BIT_LOW_FLAG])
    else $error("split low half did not reload");
  a_low_flag_any: assert property (@(posedge mclk) disable iff (rst)
    ovf_lo |=> ctrl_r[arct_pkg::BIT_LOW_FLAG])
    else $error("low rollover lost");
  a_flags_sticky: assert property (@(posedge mclk) disable iff (rst)
    (ctrl_r[arct_pkg::BIT_HIGH_FLAG] && !(sfr_wr || sfr_bit_wr)) |=>
      ctrl_r[arct_pkg::BIT_HIGH_FLAG])
    else $error("high flag cleared by hardware");
  a_capture_copy: assert property (@(posedge mclk) disable iff (rst)
    capt |=> rld_r == $past(cnt_r) && ctrl_r[arct_pkg::BIT_HIGH_FLAG])
    else $error("capture did not copy count");
  a_irq_follow: assert property (@(posedge mclk) disable iff (rst)
    (timer_irq_enable && ctrl_r[arct_pkg::BIT_LOW_IRQEN] &&
     ctrl_r[arct_pkg::BIT_LOW_FLAG]) |=> irq_request)
    else $error("low byte interrupt missing");
  a_irq_cause: assert property (@(posedge mclk) disable iff (rst)
    irq_request |-> $past(timer_irq_enable) &&
      ($past(ctrl_r[arct_pkg::BIT_HIGH_FLAG]) ||
       ($past(ctrl_r[arct_pkg::BIT_LOW_IRQEN]) && $past(ctrl_r[arct_pkg::BIT_LOW_FLAG]))))
    else $error("interrupt without flag");

endmodule : arct_timer

/* hdl/arct_pkg.sv */
package arct_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'hc8;
  localparam logic [7:0] OFS_RLD_LO   = 8'hca;
  localparam logic [7:0] OFS_RLD_HI   = 8'hcb;
  localparam logic [7:0] OFS_CNT_LO   = 8'hcc;
  localparam logic [7:0] OFS_CNT_HI   = 8'hcd;

  // ----------------------------------------------------------------
  // timer_control field positions
  // ----------------------------------------------------------------
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG  = 6;
  localparam int BIT_LOW_IRQEN = 5;
  localparam int BIT_CAPT_EN   = 4;
  localparam int BIT_SPLIT     = 3;
  localparam int BIT_RUN       = 2;
  localparam int BIT_XCLK_HI   = 1;
  localparam int BIT_XCLK_LO   = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_CTRL  = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_RLD   = 16'h0000;

  // ----------------------------------------------------------------
  // divider counts and select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SYS_DIV_LAST = 4'hb;
  localparam logic [2:0] RTC_DIV_LAST = 3'h7;
  localparam logic [1:0] XCLK_SYS12   = 2'h0;
  localparam logic [1:0] XCLK_RTC8    = 2'h1;
  localparam logic [1:0] XCLK_CMP     = 2'h3;

endpackage : arct_pkg

/* hdl/arct_tick_if.sv */
`timescale 1ns/1ps
interface arct_tick_if;
  logic sys12;
  logic rtc8;
  logic cmp_rise;
  modport src (output sys12, output rtc8, output cmp_rise);
  modport snk (input  sys12, input  rtc8, input  cmp_rise);
endinterface : arct_tick_if

/* hdl/arct_tick_gen.sv */
`timescale 1ns/1ps
module arct_tick_gen (
  input  wire logic     mclk,
  input  wire logic     rst,
  input  wire logic     rtc_clk,
  input  wire logic     cmp_out,
  arct_tick_if.src      tk
);

  logic       rtc_s1_r, rtc_s2_r, rtc_s3_r;
  logic       cmp_s1_r, cmp_s2_r, cmp_s3_r;
  logic [3:0] pre_r,    pre_nxt;
  logic [2:0] rdiv_r,   rdiv_nxt;
  logic       sys12_r,  sys12_nxt;
  logic       rtc8_r,   rtc8_nxt;
  logic       cmp_r,    cmp_nxt;
  logic       rtc_rise;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb
  begin
    rtc_rise  = rtc_s2_r & ~rtc_s3_r;
    pre_nxt   = (pre_r == arct_pkg::SYS_DIV_LAST) ? 4'h0 : pre_r + 4'h1;
    sys12_nxt = (pre_r == arct_pkg::SYS_DIV_LAST);
    rdiv_nxt  = rtc_rise ? rdiv_r + 3'h1 : rdiv_r;
    rtc8_nxt  = rtc_rise & (rdiv_r == arct_pkg::RTC_DIV_LAST);
    cmp_nxt   = cmp_s2_r & ~cmp_s3_r;
  end

  // ----------------------------------------------------------------
  // registers; s1 feeds only s2
  // ----------------------------------------------------------------
  // three-stage synchronisers; s2 and s3 also feed the edge detect
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rtc_s1_r <= 1'b0;
      rtc_s2_r <= 1'b0;
      rtc_s3_r <= 1'b0;
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      cmp_s3_r <= 1'b0;
      pre_r    <= 4'h0;
      rdiv_r   <= 3'h0;
      sys12_r  <= 1'b0;
      rtc8_r   <= 1'b0;
      cmp_r    <= 1'b0;
    end
    else
    begin
      rtc_s1_r <= rtc_clk;
      rtc_s2_r <= rtc_s1_r;
      rtc_s3_r <= rtc_s2_r;
      cmp_s1_r <= cmp_out;
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
      pre_r    <= pre_nxt;
      rdiv_r   <= rdiv_nxt;
      sys12_r  <= sys12_nxt;
      rtc8_r   <= rtc8_nxt;
      cmp_r    <= cmp_nxt;
    end
  end

  assign tk.sys12    = sys12_r;
  assign tk.rtc8     = rtc8_r;
  assign tk.cmp_rise = cmp_r;

  a_cmp_sync_edge: assert property (@(posedge mclk) disable iff (rst)
    cmp_r |-> $past(cmp_s2_r) && !$past(cmp_s3_r))
    else $error("comparator tick without synchronised edge");

endmodule : arct_tick_gen

/* verif/arct_tb.sv */
`timescale 1ns/1ps
module testbench;
  logic        mclk, rst, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, tie_en;
  logic        hsel, lsel, rtc_clk, cmp_out, irq_request;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rv;
  logic [2:0]  sfr_bit_idx;
  logic [15:0] c, rl, v;
  int          errors, total_checks, cyc;

  arct_timer dut_u (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx),
    .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata), .timer_irq_enable(tie_en),
    .high_half_clock_select(hsel), .low_half_clock_select(lsel), .rtc_clk(rtc_clk),
    .cmp_out(cmp_out), .irq_request(irq_request));

  // ------------------------------------------------------------
  // clocks and watchdog
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    rtc_clk = 1'b0;
    forever #130 rtc_clk = ~rtc_clk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // model and bus tasks
  // ------------------------------------------------------------
  function automatic int adv(int c0, int r0, int n, int m);
    for (int i = 0; i < n; i++) c0 = (c0 == m) ? r0 : c0 + 1;
    return c0;
  endfunction : adv
  task automatic chk(string nm, int lo, int hi, logic [15:0] got);
    total_checks++;
    if (^got === 1'bx || got < lo || got > hi)
    begin
      errors++;
      $display("MISMATCH %s expected %0h..%0h seen %0h", nm, lo, hi, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge mclk);
    #1 sfr_wr = 1'b0;
  endtask : wr
  task automatic bw(logic [2:0] i, logic b);
    @(posedge mclk);
    #1 sfr_addr = arct_pkg::OFS_CTRL;
    sfr_bit_idx = i;
    sfr_bit_val = b;
    sfr_bit_wr = 1'b1;
    @(posedge mclk);
    #1 sfr_bit_wr = 1'b0;
  endtask : bw
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge mclk);
    #1 sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd
  task automatic rd16(logic [7:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 8'h01, d[15:8]);
  endtask : rd16
  task automatic load16(logic [15:0] cv, logic [15:0] rv16);
    wr(arct_pkg::OFS_RLD_LO, rv16[7:0]);
    wr(arct_pkg::OFS_RLD_HI, rv16[15:8]);
    wr(arct_pkg::OFS_CNT_LO, cv[7:0]);
    wr(arct_pkg::OFS_CNT_HI, cv[15:8]);
  endtask : load16
  // run for exactly n ticks of the system clock, optional comparator pulses
  task automatic run_n(int n, bit pulse);
    bw(3'h2, 1'b1);
    for (int i = 0; i < n - 2; i++)
    begin
      @(posedge mclk);
      #1 if (pulse) cmp_out = (i % 20) < 10;
    end
    bw(3'h2, 1'b0);
    cmp_out = 1'b0;
  endtask : run_n
  task automatic irq_is(logic e);
    repeat (3) @(posedge mclk);
    #1 chk("irq_request", e, e, {15'h0, irq_request});
  endtask : irq_is
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, tie_en, hsel, lsel, cmp_out} = 8'h00;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_bit_idx = 3'h0;
    rst = 1'b1;
    void'($urandom(32'h336e));
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      rd(8'hc8 + 8'(i), rv);
      chk("reset value", 0, 0, {8'h0, rv});
    end
    $display("test reset done");
    lsel = 1'b1;
    tie_en = 1'b1;
    c = 16'h00f8 + 16'($urandom_range(3));
    rl = 16'($urandom);
    load16(c, rl);
    run_n(12, 0);
    rd16(arct_pkg::OFS_CNT_LO, v);
    chk("count16 low roll", adv(c, rl, 12, 'hffff), adv(c, rl, 12, 'hffff), v);
    rd(arct_pkg::OFS_CTRL, rv);
    chk("ctrl low flag", 'h40, 'h40, {8'h0, rv});
    irq_is(1'b0);
    bw(3'h5, 1'b1);
    irq_is(1'b1);
    bw(3'h6, 1'b0);
    bw(3'h5, 1'b0);
    c = 16'hfff8 + 16'($urandom_range(3));
    rl = 16'h8000 | 16'($urandom);
    load16(c, rl);
    run_n(12, 0);
    rd16(arct_pkg::OFS_CNT_LO, v);
    chk("count16 reload", adv(c, rl, 12, 'hffff), adv(c, rl, 12, 'hffff), v);
    irq_is(1'b1);
    tie_en = 1'b0;
    irq_is(1'b0);
    repeat (40) @(posedge mclk);
    rd(arct_pkg::OFS_CTRL, rv);
    chk("ctrl flags kept", 'hc0, 'hc0, {8'h0, rv});
    wr(arct_pkg::OFS_CTRL, 8'h00);
    $display("test sixteen bit done");
    hsel = 1'b1;
    load16(16'hfcf0, 16'h4010);
    wr(arct_pkg::OFS_CTRL, 8'h08);
    repeat (40) @(posedge mclk);
    rd(arct_pkg::OFS_CNT_HI, rv);
    chk("high held", 'hfc, 'hfc, {8'h0, rv});
    rd(arct_pkg::OFS_CTRL, rv);
    chk("split low flag", 'h48, 'h48, {8'h0, rv});
    run_n(10, 0);
    rd(arct_pkg::OFS_CNT_HI, rv);
    chk("split high", adv('hfc, 'h40, 10, 'hff), adv('hfc, 'h40, 10, 'hff), {8'h0, rv});
    tie_en = 1'b1;
    irq_is(1'b1);
    bw(3'h7, 1'b0);
    irq_is(1'b0);
    bw(3'h5, 1'b1);
    irq_is(1'b1);
    wr(arct_pkg::OFS_CTRL, 8'h00);
    $display("test split done");
    lsel = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      load16(16'h0000, 16'h0000);
      wr(arct_pkg::OFS_CTRL, 8'(k));
      run_n(k == 1 ? 420 : 120, k == 3);
      rd16(arct_pkg::OFS_CNT_LO, v);
      case (k)
        0: chk("sys12 ticks", 10, 10, v);
        1: chk("rtc8 ticks", 9, 11, v);
        2: chk("reserved ticks", 0, 0, v);
        default: chk("cmp ticks", 6, 6, v);
      endcase
    end
    $display("test clock select done");
    // stay in 16-bit mode and clock fast while capturing
    lsel = 1'b1;
    load16(16'h0000, 16'h0000);
    wr(arct_pkg::OFS_CTRL, 8'h13);
    run_n(100, 1);
    rd16(arct_pkg::OFS_RLD_LO, v);
    chk("captured count", 80, 90, v);
    rd(arct_pkg::OFS_CTRL, rv);
    chk("capture flag", 'h93, 'h93, {8'h0, rv});
    irq_is(1'b1);
    wr(arct_pkg::OFS_CTRL, 8'h10);
    run_n(300, 0);
    rd(arct_pkg::OFS_CTRL, rv);
    chk("rtc capture flag", 'hd0, 'hd0, {8'h0, rv});
    rd16(arct_pkg::OFS_RLD_LO, v);
    chk("rtc captured count", 350, 400, v);
    $display("test capture done");
    final_report();
  end
endmodule : testbench
